// [bench/tb_top.sv]
// self-checking testbench for the timer pwm capture unit
`timescale 1ns/1ps
module tb_top;
  import tpcu_pkg::*;
  // ==========================================================
  // signals
  logic          clk, rst_n, fix, ext, ext_en, cmp, pu, ovf;
  logic [1:0]    lvl, pin, chi;
  logic [3:0]    fdiv = 4'h0;
  logic [7:0]    rdata;
  tpcu_bus_req_t bus;
  tpcu_pins_t    pins;
  int            err_total = 0;
  int            n_checks  = 0;
  always #2 clk = ~clk;
  // fixed clock at one sixteenth of the bus rate
  always @(posedge clk) fdiv <= fdiv + 4'h1;
  assign fix = fdiv[3];
  tpcu_top u_dut (.i_sys_clk(clk), .i_rstn(rst_n), .i_bus(bus), .o_rdata(rdata),
    .i_fix_tick(fix), .i_ext_clk(ext), .i_cmp_out(cmp), .i_ch_pin(pin), .o_pins(pins),
    .o_pullup_en(pu), .o_ovf_irq(ovf), .o_ch_irq(chi));
  tpcu_pin_model u_pins (.i_sys_clk(clk), .i_ext_en(ext_en), .i_lvl(lvl), .i_pins(pins),
    .o_ext_clk(ext), .o_ch_pin(pin));
  // ==========================================================
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= {a, 8'h00, 2'b01};
    cyc(1);
    bus <= '0;
    d = rdata;
  endtask
  task automatic chkr(input string nm, input logic [15:0] lo, hi, g);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_total++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    chkr(nm, e, e, g);
  endtask
  task automatic rcnt(output logic [15:0] v);
    logic [7:0] h, l;
    rd(ADDR_CNT_HI, h);
    rd(ADDR_CNT_LO, l);
    v = {h, l};
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] d;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      chk("reg reset", 16'h0000, {8'h00, d});
    end
    chk("pin reset", 16'h0003, {8'h00, pu, ovf, chi, pins.own, pins.oe_n});
    $display("t_reset done");
  endtask
  task automatic t_count;
    logic [7:0]  d;
    logic [15:0] v;
    wr(ADDR_GCTRL, 8'h08);
    wr(ADDR_CNT_LO, 8'h5A);
    rd(ADDR_CNT_HI, d);
    chk("cnt cleared", 16'h0000, {8'h00, d});
    cyc(400);
    rd(ADDR_CNT_LO, d);
    chkr("latched low", 16'h0001, 16'h0008, {8'h00, d});
    rcnt(v);
    chkr("free count", 16'd400, 16'd425, v);
    $display("t_count done");
  endtask
  task automatic t_clk;
    logic [15:0] v;
    int          e;
    for (int i = 0; i < 11; i++) begin
      ext_en <= (i == 9);
      // ch0 edge/level stays 0:0 while the pin carries the clock
      wr(ADDR_GCTRL, i < 8 ? {5'h01, 3'(i)} : i == 8 ? 8'h10 : i == 9 ? 8'h18 : 8'h00);
      wr(ADDR_CNT_HI, 8'hFF);
      cyc(256);
      rcnt(v);
      e = i == 10 ? 0 : 258 / (i < 8 ? 1 << i : i == 8 ? 16 : 8);
      chkr("rate", 16'(e > 2 ? e - 2 : 0), 16'(e ? e + 2 : 0), v);
    end
    $display("t_clk done");
  endtask
  task automatic t_ovf;
    logic [7:0]  d;
    logic [15:0] v;
    wr(ADDR_MOD_LO, 8'h10);
    wr(ADDR_GCTRL, 8'h4F);
    wr(ADDR_CNT_LO, 8'h00);
    cyc(2400);
    rd(ADDR_GCTRL, d);
    chk("ovf set", 16'h01CF, {7'h00, ovf, d});
    wr(ADDR_GCTRL, 8'h4F);
    rd(ADDR_GCTRL, d);
    chk("ovf clear", 16'h004F, {7'h00, ovf, d});
    rcnt(v);
    chkr("wrap", 16'h0000, 16'h0010, v);
    $display("t_ovf done");
  endtask
  task automatic t_cmp;
    logic [7:0] d;
    logic [7:0] mk [3] = '{8'h54, 8'h18, 8'h1C};
    logic       p;
    wr(ADDR_GCTRL, 8'h08);
    wr(ADDR_C0_VLO, 8'h08);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_C0_CTRL, mk[k]);
      cyc(40);
      p = pins.out[0];
      cyc(17);
      chk("compare", {15'h0, k ? mk[k][2] : ~p}, {pins.oe_n[0], 14'h0, pins.out[0]});
    end
    chk("ch irq", 16'h0000, {15'h0, chi[0]});
    wr(ADDR_C0_CTRL, 8'h00);
    cyc(2);
    chk("pin freed", 16'h0001, {14'h0, pins.own[0], pins.oe_n[0]});
    rd(ADDR_C0_CTRL, d);
    chk("flag seen", 16'h0001, {15'h0, d[7]});
    wr(ADDR_C0_CTRL, 8'h40);
    cyc(1);
    chk("flag cleared", 16'h0000, {15'h0, chi[0]});
    ext_en <= 1'b1;
    wr(ADDR_GCTRL, 8'h18);
    wr(ADDR_C0_CTRL, 8'h50);
    cyc(300);
    chk("soft timer", 16'h0001, {14'h0, pins.own[0], chi[0]});
    ext_en <= 1'b0;
    $display("t_cmp done");
  endtask
  task automatic t_pwm;
    logic [15:0] n;
    wr(ADDR_MOD_LO, 8'h0F);
    wr(ADDR_GCTRL, 8'h08);
    wr(ADDR_C1_VLO, 8'h04);
    // third pass runs the whole timer center-aligned: period 30 against 16
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        wr(ADDR_GCTRL, 8'h28);
      end
      wr(ADDR_C1_CTRL, k == 1 ? 8'h24 : 8'h28);
      wr(ADDR_CNT_LO, 8'h00);
      cyc(40);
      n = 16'h0000;
      repeat (240) begin
        cyc(1);
        n = n + pins.out[1];
      end
      chk("pwm width", k == 2 ? 16'd56 : k ? 16'd180 : 16'd60, n);
    end
    wr(ADDR_GCTRL, 8'h08);
    wr(ADDR_C1_CTRL, 8'h00);
    $display("t_pwm done");
  endtask
  task automatic t_cap;
    logic [7:0] d;
    logic [1:0] el;
    for (int i = 0; i < 6; i++) begin
      el = 2'(i / 2 + 1);
      lvl[1] <= i[0];
      wr(ADDR_C1_CTRL, {4'h0, el, 2'b00});
      cyc(4);
      rd(ADDR_C1_CTRL, d);
      wr(ADDR_C1_CTRL, {4'h0, el, 2'b00});
      lvl[1] <= ~i[0];
      cyc(8);
      rd(ADDR_C1_CTRL, d);
      chk("capture edge", {15'h0, i[0] ? el[1] : el[0]}, {15'h0, d[7]});
    end
    wr(ADDR_SYSOPT, 8'h01);
    wr(ADDR_C0_CTRL, 8'h04);
    rd(ADDR_C0_CTRL, d);
    wr(ADDR_C0_CTRL, 8'h04);
    cmp <= 1'b1;
    cyc(8);
    rd(ADDR_C0_CTRL, d);
    chk("cmp capture", 16'h0001, {14'h0, pins.own[0], d[7]});
    $display("t_cap done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {clk, rst_n, ext_en, cmp, lvl} = '0;
    bus = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_count;
    t_clk;
    t_ovf;
    t_cmp;
    t_pwm;
    t_cap;
    conclude;
  end
  initial begin
    cyc(30000);
    err_total++;
    conclude;
  end
endmodule // tb_top
bind tpcu_top tpcu_assertions u_chk (.i_sys_clk, .i_rstn, .i_bus, .o_rdata, .o_pins,
  .o_pullup_en, .o_ovf_irq);

// [bench/tpcu_assertions.sv]
// checker of the timer pwm capture unit port behaviour
`timescale 1ns/1ps
module tpcu_assertions
  import tpcu_pkg::*;
(
  // clock and reset
  input wire logic                    i_sys_clk,
  input wire logic                    i_rstn,
  // watched ports
  input wire tpcu_pkg::tpcu_bus_req_t i_bus,
  input wire logic [7:0]              o_rdata,
  input wire tpcu_pkg::tpcu_pins_t    o_pins,
  input wire logic                    o_pullup_en,
  input wire logic                    o_ovf_irq
);
  // ==========================================================
  // shadow of software settings
  logic [6:0] gc_reg;
  logic       cmp_reg;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      gc_reg  <= 7'h00;
      cmp_reg <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == ADDR_GCTRL) begin
      gc_reg <= i_bus.wdata[6:0];
    end else if (i_bus.wr && i_bus.addr == ADDR_SYSOPT) begin
      cmp_reg <= i_bus.wdata[SO_CMPSEL];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // properties
  sequence cnt_clr_s;
    i_bus.wr && i_bus.addr == ADDR_CNT_LO ##2 i_bus.rd && i_bus.addr == ADDR_CNT_HI;
  endsequence
  rd_idle_a: assert property (!i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a: assert property (i_bus.rd && i_bus.addr > ADDR_SYSOPT |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  pullup_off_a: assert property (o_pullup_en == 1'b0)
    else $error("pullup enabled");
  reset_pins_a: assert property ($rose(i_rstn) |-> o_pins.oe_n == 2'h3 && o_pins.own == 2'h0)
    else $error("pins not released after reset");
  drive_owned_a: assert property ((~o_pins.oe_n & ~o_pins.own) == 2'h0)
    else $error("pin driven without ownership");
  cmp_release_a: assert property (cmp_reg && $past(cmp_reg) |-> !o_pins.own[0] && o_pins.oe_n[0])
    else $error("channel 0 pin kept under comparator steering");
  ext_release_a: assert property (gc_reg[GC_CLK_H:GC_CLK_L] == 2'h3 && $stable(gc_reg) |-> !o_pins.own[0])
    else $error("channel 0 pin kept under external clock");
  ovf_mask_a: assert property (!gc_reg[GC_OVFIE] && $stable(gc_reg) |-> !o_ovf_irq)
    else $error("overflow request while masked");
  cnt_clear_a: assert property (cnt_clr_s |=> o_rdata == 8'h00)
    else $error("counter not cleared by write");
  cover property (o_ovf_irq);
  cover property (!o_pins.oe_n[1]);
  cover property (cnt_clr_s);
endmodule // tpcu_assertions

// [bench/tpcu_pin_model.sv]
// far-side model: external count clock and channel pin levels
`timescale 1ns/1ps
module tpcu_pin_model
  import tpcu_pkg::*;
#(
  parameter int HALF = 4
) (
  // clock
  input  wire logic                 i_sys_clk,
  // bench control
  input  wire logic                 i_ext_en,
  input  wire logic [1:0]           i_lvl,
  // device pins
  input  wire tpcu_pkg::tpcu_pins_t i_pins,
  output logic                      o_ext_clk,
  output logic [1:0]                o_ch_pin
);
  logic clk_q = 1'b0;
  int   cnt   = 0;
  // stands low when unused; 2*HALF bus cycles stays under a quarter rate
  always @(posedge i_sys_clk) begin
    if (!i_ext_en) begin
      cnt   <= 0;
      clk_q <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt   <= 0;
      clk_q <= ~clk_q;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign o_ext_clk = clk_q;
  // pin 0 doubles as count clock input; a driven pin reads back the timer level
  assign o_ch_pin[0] = i_ext_en ? clk_q : (i_pins.oe_n[0] ? i_lvl[0] : i_pins.out[0]);
  assign o_ch_pin[1] = i_pins.oe_n[1] ? i_lvl[1] : i_pins.out[1];
endmodule // tpcu_pin_model

// [design/tpcu_clk_gen.sv]
// count enable source: clock selection, synchroniser and prescaler
`timescale 1ns/1ps
module tpcu_clk_gen (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // control
  input  wire logic [1:0]  i_clk_sel,
  input  wire logic [2:0]  i_dv_sel,
  // raw sources
  input  wire logic        i_fix_tick,
  input  wire logic        i_ext_clk,
  // single-cycle count enable
  output logic             o_tick
);
  import tpcu_pkg::*;

  logic       ext_s1_reg;
  logic       ext_s2_reg;
  logic       ext_s3_reg;
  logic       fix_s1_reg;
  logic       fix_s2_reg;
  logic       fix_s3_reg;
  logic [6:0] dv_reg;
  logic [6:0] dv_next;
  logic [6:0] dv_mask;
  logic       src_tick;
  logic       ext_rise;
  logic       fix_rise;

  assign ext_rise = ext_s2_reg & ~ext_s3_reg;
  assign fix_rise = fix_s2_reg & ~fix_s3_reg;

  // ==========================================================
  // source selection
  assign src_tick = (i_clk_sel == TPCU_CLK_BUS) ? 1'b1 :
                    (i_clk_sel == TPCU_CLK_FIX) ? fix_rise :
                    (i_clk_sel == TPCU_CLK_EXT) ? ext_rise :
                    1'b0;

  // ==========================================================
  // divide by two to the power of the field
  assign dv_mask = 7'((8'h01 << i_dv_sel) - 8'h01);
  assign dv_next = src_tick ? ((dv_reg & dv_mask) + 7'h01) & dv_mask : dv_reg;
  assign o_tick  = src_tick & ((dv_reg & dv_mask) == dv_mask);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      fix_s1_reg <= 1'b0;
      fix_s2_reg <= 1'b0;
      fix_s3_reg <= 1'b0;
      dv_reg     <= DV_ZERO;
    end else begin
      ext_s1_reg <= i_ext_clk;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      fix_s1_reg <= i_fix_tick;
      fix_s2_reg <= fix_s1_reg;
      fix_s3_reg <= fix_s2_reg;
      // stopped source holds the prescaler at zero
      dv_reg     <= (i_clk_sel == TPCU_CLK_OFF) ? DV_ZERO : dv_next;
    end
  end

endmodule // tpcu_clk_gen

// [design/tpcu_top.sv]
// timer pwm capture unit: 16-bit counter, two channels, register port
//
// Notes on behaviour
// - comparator select bit routes comparator into channel 0 capture, pin released.
// - clock source 1:1 picks the external clock pin, shareable elsewhere.
// - prescaler divides selected clock by 1 to 128 in powers of two.
// - 16-bit counter counts up, or up/down in center-aligned mode.
// - modulo 0x0000 or 0xFFFF gives full-range free running.
// - counter reads never disturb counting.
// - any write to either counter byte clears the counter, data ignored.
// - channel losing its pin still runs output compare internally.
// - after reset timer disabled, pins are inputs, pullups off.
// - while timer owns a pin, port settings do not reach it.
// - channel needing no pin returns it to port control.
// - channels independently capture, compare or PWM; center mode is global.
// - capture on rising, falling or either edge per channel.
// - compare match sets, clears or toggles the channel output.
// - PWM output polarity selectable high-true or low-true.
// - one interrupt per channel plus one overflow interrupt.
// - 8-bit global control, 16-bit counter and modulo, per-channel control and value.
// - in up mode the counter is the common channel time base.
// - clock source is bus clock, fixed clock or external pin.
// - source field 0:0 off, 0:1 bus, 1:0 fixed, 1:1 external.
// - 3-bit prescale field divides by two to its value, after selection.
// - overflow flag set on wrap, or at the turn from the top in center mode; clears by read-set then write 0.
// - reading one counter byte latches both until the next read of either counter byte or a write to a counter byte or global control.
`timescale 1ns/1ps
module tpcu_top (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rstn,
  // register port
  input  wire tpcu_pkg::tpcu_bus_req_t  i_bus,
  output logic [7:0]                    o_rdata,
  // clock sources
  input  wire logic                     i_fix_tick,
  input  wire logic                     i_ext_clk,
  // comparator output
  input  wire logic                     i_cmp_out,
  // channel pins
  input  wire logic [1:0]               i_ch_pin,
  output tpcu_pkg::tpcu_pins_t          o_pins,
  output logic                          o_pullup_en,
  // interrupts
  output logic                          o_ovf_irq,
  output logic [1:0]                    o_ch_irq
);
  import tpcu_pkg::*;

  // ==========================================================
  // registers
  logic [7:0]  gctrl_reg;
  logic [7:0]  sysopt_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        dn_reg;
  logic        dn_next;
  logic [15:0] mod_reg;
  logic [15:0] latch_reg;
  logic        latched_reg;
  logic        ovf_armed_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  cctrl_reg [NUM_CH];
  logic [15:0] cval_reg  [NUM_CH];
  logic [15:0] cbuf_reg  [NUM_CH];
  logic [NUM_CH-1:0] carm_reg;
  logic [NUM_CH-1:0] cout_reg;
  logic [NUM_CH-1:0] cin_reg;
  logic        tick;

  // ==========================================================
  // bus decode
  logic        wr_g;
  logic        wr_cnt;
  logic        rd_cnt;
  logic        rd_g;
  logic        wr_mhi;
  logic        wr_mlo;
  logic        wr_so;
  logic [7:0]  rd_mux;
  logic        symm;
  logic [1:0]  clk_sel;
  logic [15:0] top_val;
  logic        at_top;
  logic        ovf_evt;
  logic        ovf_clr;

  assign wr_g    = i_bus.wr & (i_bus.addr == ADDR_GCTRL);
  assign rd_g    = i_bus.rd & (i_bus.addr == ADDR_GCTRL);
  assign wr_cnt  = i_bus.wr & ((i_bus.addr == ADDR_CNT_HI) | (i_bus.addr == ADDR_CNT_LO));
  assign rd_cnt  = i_bus.rd & ((i_bus.addr == ADDR_CNT_HI) | (i_bus.addr == ADDR_CNT_LO));
  assign wr_mhi  = i_bus.wr & (i_bus.addr == ADDR_MOD_HI);
  assign wr_mlo  = i_bus.wr & (i_bus.addr == ADDR_MOD_LO);
  assign wr_so   = i_bus.wr & (i_bus.addr == ADDR_SYSOPT);
  assign symm    = gctrl_reg[GC_SYMM];
  assign clk_sel = gctrl_reg[GC_CLK_H:GC_CLK_L];

  // channel register index: 0 for control, 1 value high, 2 value low
  function automatic logic [3:0] ch_base(input int ch);
    ch_base = 4'(ADDR_C0_CTRL + 4'(ch) * CH_STRIDE);
  endfunction

  // ==========================================================
  // count enable from selected, synchronised, prescaled source
  tpcu_clk_gen u_clk_gen (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_clk_sel  (clk_sel),
    .i_dv_sel   (gctrl_reg[GC_DV_H:GC_DV_L]),
    .i_fix_tick (i_fix_tick),
    .i_ext_clk  (i_ext_clk),
    .o_tick     (tick)
  );

  // ==========================================================
  // counter sequence
  assign top_val = ((mod_reg == CNT_ZERO) | (mod_reg == MOD_FULL)) ? MOD_FULL : mod_reg;
  assign at_top  = (cnt_reg == top_val);

  always_comb begin
    cnt_next = cnt_reg;
    dn_next  = dn_reg;
    ovf_evt  = 1'b0;
    if (tick) begin
      if (symm) begin
        if (!dn_reg && at_top) begin
          dn_next  = 1'b1;
          cnt_next = 16'(cnt_reg - CNT_ONE);
          ovf_evt  = 1'b1;
        end else if (dn_reg && (cnt_reg == CNT_ONE)) begin
          dn_next  = 1'b0;
          cnt_next = CNT_ZERO;
        end else begin
          cnt_next = dn_reg ? 16'(cnt_reg - CNT_ONE) : 16'(cnt_reg + CNT_ONE);
        end
      end else if (at_top) begin
        cnt_next = CNT_ZERO;
        ovf_evt  = 1'b1;
      end else begin
        cnt_next = 16'(cnt_reg + CNT_ONE);
      end
    end
  end

  // flag clears on write 0 after a read saw it set; new overflow wins
  assign ovf_clr = wr_g & ~i_bus.wdata[GC_OVF] & ovf_armed_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      gctrl_reg     <= RST_BYTE;
      sysopt_reg    <= RST_BYTE;
      cnt_reg       <= CNT_ZERO;
      dn_reg        <= 1'b0;
      mod_reg       <= CNT_ZERO;
      ovf_armed_reg <= 1'b0;
    end else begin
      // counter write clears, data unused
      cnt_reg <= wr_cnt ? CNT_ZERO : cnt_next;
      dn_reg  <= wr_cnt ? 1'b0 : dn_next;
      if (wr_g) begin
        gctrl_reg[GC_OVFIE:GC_DV_L] <= i_bus.wdata[GC_OVFIE:GC_DV_L];
      end
      if (ovf_evt) begin
        gctrl_reg[GC_OVF] <= 1'b1;
      end else if (ovf_clr) begin
        gctrl_reg[GC_OVF] <= 1'b0;
      end
      if (ovf_evt) begin
        ovf_armed_reg <= 1'b0;
      end else if (rd_g && gctrl_reg[GC_OVF]) begin
        ovf_armed_reg <= 1'b1;
      end else if (wr_g) begin
        ovf_armed_reg <= 1'b0;
      end
      if (wr_mhi) begin
        mod_reg[15:8] <= i_bus.wdata;
      end
      if (wr_mlo) begin
        mod_reg[7:0] <= i_bus.wdata;
      end
      if (wr_so) begin
        sysopt_reg <= i_bus.wdata;
      end
    end
  end

  // ==========================================================
  // coherent counter read latch
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      latch_reg   <= CNT_ZERO;
      latched_reg <= 1'b0;
    end else if (wr_cnt || wr_g) begin
      latched_reg <= 1'b0;
    end else if (rd_cnt) begin
      latched_reg <= ~latched_reg;
      if (!latched_reg) begin
        latch_reg <= cnt_reg;
      end
    end
  end

  // ==========================================================
  // channels
  logic [NUM_CH-1:0] cin_src;
  logic [NUM_CH-1:0] cap_evt;
  logic [NUM_CH-1:0] cmp_evt;
  logic [NUM_CH-1:0] pwm_on;
  logic [NUM_CH-1:0] pin_free;
  logic [NUM_CH-1:0] pin_drive;
  logic [NUM_CH-1:0] cflag_set;

  // comparator takes channel 0 input and denies its pin
  assign cin_src[0] = sysopt_reg[SO_CMPSEL] ? i_cmp_out : i_ch_pin[0];
  assign cin_src[1] = i_ch_pin[1];

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [1:0] ms;
    logic [1:0] el;
    logic       rise;
    logic       fall;
    logic       ctrl_wr;
    logic       vhi_wr;
    logic       vlo_wr;
    logic       c_rd;
    logic       shared;
    logic       level;
    assign ms      = cctrl_reg[g][CC_MS_H:CC_MS_L];
    assign el      = cctrl_reg[g][CC_EL_H:CC_EL_L];
    assign ctrl_wr = i_bus.wr & (i_bus.addr == ch_base(g));
    assign vhi_wr  = i_bus.wr & (i_bus.addr == 4'(ch_base(g) + 4'h1));
    assign vlo_wr  = i_bus.wr & (i_bus.addr == 4'(ch_base(g) + 4'h2));
    assign c_rd    = i_bus.rd & (i_bus.addr == ch_base(g));
    assign rise    = cin_src[g] & ~cin_reg[g];
    assign fall    = ~cin_src[g] & cin_reg[g];
    // channel 0 shares the external clock pin
    assign shared  = (g == 0) & (clk_sel == TPCU_CLK_EXT);
    // capture when mode 00, edge select non-zero, clock source not off and not center-aligned
    assign cap_evt[g] = ~symm & (ms == 2'h0) & (clk_sel != TPCU_CLK_OFF) &
                        ((el[0] & rise) | (el[1] & fall));
    assign cmp_evt[g] = tick & ~symm & (ms == 2'h1) & (cnt_next == cval_reg[g]);
    assign pwm_on[g]  = symm | ms[1];
    // high-true pulse when el[0] is clear, low-true when el[0] is set
    assign level      = (cnt_reg < cval_reg[g]);
    assign pin_free[g] = (el == EL_NONE) | shared |
                         ((g == 0) & sysopt_reg[SO_CMPSEL]);
    assign pin_drive[g] = ~pin_free[g] & (pwm_on[g] | (ms == 2'h1));
    assign cflag_set[g] = cap_evt[g] | cmp_evt[g] | (pwm_on[g] & ovf_evt);

    always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
        cctrl_reg[g] <= RST_BYTE;
        cval_reg[g]  <= CNT_ZERO;
        cbuf_reg[g]  <= CNT_ZERO;
        carm_reg[g]  <= 1'b0;
        cout_reg[g]  <= 1'b0;
        cin_reg[g]   <= 1'b0;
      end else begin
        cin_reg[g] <= cin_src[g];
        if (ctrl_wr) begin
          cctrl_reg[g][CC_IE:CC_EL_L] <= i_bus.wdata[CC_IE:CC_EL_L];
        end
        // flag: set wins over clear, clear is read-set then write 0
        if (cflag_set[g]) begin
          cctrl_reg[g][CC_FLAG] <= 1'b1;
          carm_reg[g]           <= 1'b0;
        end else begin
          if (ctrl_wr && carm_reg[g] && !i_bus.wdata[CC_FLAG]) begin
            cctrl_reg[g][CC_FLAG] <= 1'b0;
          end
          if (c_rd && cctrl_reg[g][CC_FLAG]) begin
            carm_reg[g] <= 1'b1;
          end else if (ctrl_wr) begin
            carm_reg[g] <= 1'b0;
          end
        end
        // buffered value: pwm takes new duty at period end
        if (vhi_wr) begin
          cbuf_reg[g][15:8] <= i_bus.wdata;
        end
        if (vlo_wr) begin
          cbuf_reg[g][7:0] <= i_bus.wdata;
        end
        if (cap_evt[g]) begin
          cval_reg[g] <= cnt_reg;
        end else if (!pwm_on[g] && (vhi_wr || vlo_wr)) begin
          cval_reg[g] <= {vhi_wr ? i_bus.wdata : cval_reg[g][15:8],
                          vlo_wr ? i_bus.wdata : cval_reg[g][7:0]};
        end else if (pwm_on[g] && (ovf_evt || clk_sel == TPCU_CLK_OFF)) begin
          cval_reg[g] <= cbuf_reg[g];
        end
        if (cmp_evt[g]) begin
          case (el)
            2'h1:    cout_reg[g] <= ~cout_reg[g];
            2'h2:    cout_reg[g] <= 1'b0;
            2'h3:    cout_reg[g] <= 1'b1;
            default: cout_reg[g] <= cout_reg[g];
          endcase
        end else if (pwm_on[g]) begin
          cout_reg[g] <= el[0] ? ~level : level;
        end
      end
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  logic [7:0] cnt_view_hi;
  logic [7:0] cnt_view_lo;
  assign cnt_view_hi = latched_reg ? latch_reg[15:8] : cnt_reg[15:8];
  assign cnt_view_lo = latched_reg ? latch_reg[7:0]  : cnt_reg[7:0];

  always_comb begin
    case (i_bus.addr)
      ADDR_GCTRL:   rd_mux = gctrl_reg;
      ADDR_CNT_HI:  rd_mux = cnt_view_hi;
      ADDR_CNT_LO:  rd_mux = cnt_view_lo;
      ADDR_MOD_HI:  rd_mux = mod_reg[15:8];
      ADDR_MOD_LO:  rd_mux = mod_reg[7:0];
      ADDR_C0_CTRL: rd_mux = cctrl_reg[0];
      ADDR_C0_VHI:  rd_mux = cval_reg[0][15:8];
      ADDR_C0_VLO:  rd_mux = cval_reg[0][7:0];
      ADDR_C1_CTRL: rd_mux = cctrl_reg[1];
      ADDR_C1_VHI:  rd_mux = cval_reg[1][15:8];
      ADDR_C1_VLO:  rd_mux = cval_reg[1][7:0];
      ADDR_SYSOPT:  rd_mux = sysopt_reg;
      default:      rd_mux = RST_BYTE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rdata_reg <= RST_BYTE;
    end else begin
      rdata_reg <= i_bus.rd ? rd_mux : RST_BYTE;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata     = rdata_reg;
  assign o_pins.out  = cout_reg;
  assign o_pins.oe_n = ~pin_drive;
  assign o_pins.own  = ~pin_free;
  // pullups stay off: no pullup control is modelled here
  assign o_pullup_en = 1'b0;
  assign o_ovf_irq   = gctrl_reg[GC_OVF] & gctrl_reg[GC_OVFIE];
  assign o_ch_irq[0] = cctrl_reg[0][CC_FLAG] & cctrl_reg[0][CC_IE];
  assign o_ch_irq[1] = cctrl_reg[1][CC_FLAG] & cctrl_reg[1][CC_IE];

endmodule // tpcu_top

// [pkg/tpcu_pkg.sv]
// package for the timer pwm capture unit: register map, fields, modes
package tpcu_pkg;

  // ==========================================================
  // register byte offsets (8-bit registers, plain port)
  localparam logic [3:0] ADDR_GCTRL   = 4'h0;
  localparam logic [3:0] ADDR_CNT_HI  = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO  = 4'h2;
  localparam logic [3:0] ADDR_MOD_HI  = 4'h3;
  localparam logic [3:0] ADDR_MOD_LO  = 4'h4;
  localparam logic [3:0] ADDR_C0_CTRL = 4'h5;
  localparam logic [3:0] ADDR_C0_VHI  = 4'h6;
  localparam logic [3:0] ADDR_C0_VLO  = 4'h7;
  localparam logic [3:0] ADDR_C1_CTRL = 4'h8;
  localparam logic [3:0] ADDR_C1_VHI  = 4'h9;
  localparam logic [3:0] ADDR_C1_VLO  = 4'hA;
  localparam logic [3:0] ADDR_SYSOPT  = 4'hB;
  localparam logic [3:0] CH_STRIDE    = 4'h3;

  // ==========================================================
  // global control fields
  localparam int GC_OVF   = 7;
  localparam int GC_OVFIE = 6;
  localparam int GC_SYMM  = 5;
  localparam int GC_CLK_H = 4;
  localparam int GC_CLK_L = 3;
  localparam int GC_DV_H  = 2;
  localparam int GC_DV_L  = 0;

  // channel control fields
  localparam int CC_FLAG  = 7;
  localparam int CC_IE    = 6;
  localparam int CC_MS_H  = 5;
  localparam int CC_MS_L  = 4;
  localparam int CC_EL_H  = 3;
  localparam int CC_EL_L  = 2;

  // system option: comparator steering bit
  localparam int SO_CMPSEL = 0;

  localparam int          NUM_CH     = 2;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] MOD_FULL   = 16'hFFFF;
  localparam logic [1:0]  EL_NONE    = 2'h0;
  localparam logic [6:0]  DV_ZERO    = 7'h00;

  typedef enum logic [1:0] {
    TPCU_CLK_OFF = 2'h0,
    TPCU_CLK_BUS = 2'h1,
    TPCU_CLK_FIX = 2'h2,
    TPCU_CLK_EXT = 2'h3
  } tpcu_clksrc_t;

  // ==========================================================
  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tpcu_bus_req_t;

  // channel pin group: oe low while the timer drives the pin
  typedef struct packed {
    logic [NUM_CH-1:0] out;
    logic [NUM_CH-1:0] oe_n;
    logic [NUM_CH-1:0] own;
  } tpcu_pins_t;

endpackage
